/* File: smtia_arbiter.sv */
`timescale 1ns/10ps
module smtia_arbiter
  import smtia_pkg::*;
#(
  parameter int CORES   = CORE_COUNT,
  parameter int THREADS = CORES * THREADS_PER_CORE
)(
  input  wire logic                        ref_clk_in,
  input  wire logic                        reset_n_in,
  input  wire logic [THREADS-1:0]          thread_run_in,
  input  wire logic [THREADS-1:0]          thread_suspend_in,
  input  wire logic [THREADS-1:0]          thread_resume_in,
  input  wire logic [THREADS-1:0]          issue_req_in,
  input  wire logic [THREADS-1:0]          commit_req_in,
  input  wire logic [CORES-1:0]            async_err_in,
  input  wire logic [THREADS-1:0]          sync_err_in,
  input  wire smtia_decode_t [THREADS-1:0] decode_in,
  input  wire logic                        debug_enable_in,
  input  wire smtia_asi_wr_t               asi_wr_in,
  input  wire logic [THREADS-1:0]          pc_load_in,
  input  wire logic [ADDR_WIDTH-1:0]       pc_value_in,
  output logic [THREADS-1:0]               issue_grant_out,
  output logic [THREADS-1:0]               commit_grant_out,
  output logic [2:0]                       issue_slots_out,
  output logic [CORES-1:0]                 single_thread_out,
  output logic [THREADS-1:0]               resource_pool_out,
  output logic [THREADS-1:0]               async_err_out,
  output smtia_trap_t [THREADS-1:0]        trap_out,
  output smtia_thread_state_t [THREADS-1:0] thread_state_out,
  output logic [ADDR_WIDTH-1:0]            pc_out [THREADS],
  output logic [ADDR_WIDTH-1:0]            npc_out [THREADS],
  output logic [INST_WIDTH-1:0]            debug_match_out,
  output logic [ADDR_WIDTH-1:0]            pa_watch_out,
  output logic [ADDR_WIDTH-1:0]            va_watch_out,
  output logic [ADDR_WIDTH-1:0]            serial_out,
  output logic [CORES-1:0]                 tlb_owner_out
);
  localparam logic [ASI_WIDTH-1:0]  WATCH_ASI  = 8'h58;
  localparam logic [ADDR_WIDTH-1:0] PA_WATCH_VA = 64'h40;
  localparam logic [ADDR_WIDTH-1:0] VA_WATCH_VA = 64'h38;
  localparam logic [2:0]            SLOTS = 3'h4;

  logic [INST_WIDTH-1:0] debug_match_reg;
  logic [ADDR_WIDTH-1:0] pa_watch_reg;
  logic [ADDR_WIDTH-1:0] va_watch_reg;
  // Module-wide shared copies
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      debug_match_reg <= DEBUG_MATCH_RESET;
      pa_watch_reg    <= WATCH_RESET;
      va_watch_reg    <= WATCH_RESET;
    end else if (asi_wr_in.write) begin
      if (asi_wr_in.asi == DEBUG_MATCH_ASI && asi_wr_in.va == DEBUG_MATCH_VA) begin
        debug_match_reg <= asi_wr_in.data[INST_WIDTH-1:0];
      end
      if (asi_wr_in.asi == WATCH_ASI && asi_wr_in.va == PA_WATCH_VA) begin
        pa_watch_reg <= asi_wr_in.data;
      end
      if (asi_wr_in.asi == WATCH_ASI && asi_wr_in.va == VA_WATCH_VA) begin
        va_watch_reg <= asi_wr_in.data;
      end
    end
  end

  assign debug_match_out = debug_match_reg;
  assign pa_watch_out    = pa_watch_reg;
  assign va_watch_out    = va_watch_reg;
  assign serial_out      = SERIAL_DEFAULT;
  assign issue_slots_out = SLOTS;

  genvar t;
  generate
    for (t = 0; t < THREADS; t++) begin : g_thread
      smtia_thread_state_t state_reg;
      logic [ADDR_WIDTH-1:0] pc_reg;
      logic [ADDR_WIDTH-1:0] npc_reg;

      // Suspend wins over resume when both arrive together
      always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          state_reg <= SMTIA_EMPTY;
        end else begin
          unique case (state_reg)
            SMTIA_ACTIVE: begin
              if (thread_suspend_in[t]) state_reg <= SMTIA_SUSPEND;
              else if (!thread_run_in[t]) state_reg <= SMTIA_EMPTY;
            end
            SMTIA_EMPTY: begin
              if (thread_suspend_in[t]) state_reg <= SMTIA_SUSPEND;
              else if (thread_run_in[t]) state_reg <= SMTIA_ACTIVE;
            end
            SMTIA_SUSPEND: begin
              if (thread_resume_in[t] && !thread_suspend_in[t]) state_reg <= SMTIA_EMPTY;
            end
            default: state_reg <= SMTIA_EMPTY;
          endcase
        end
      end

      // Private program counter pair per thread
      always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          pc_reg  <= WATCH_RESET;
          npc_reg <= WATCH_RESET;
        end else if (pc_load_in[t]) begin
          pc_reg  <= pc_value_in;
          npc_reg <= pc_value_in + 64'h4;
        end else if (commit_grant_out[t]) begin
          pc_reg  <= npc_reg;
          npc_reg <= npc_reg + 64'h4;
        end
      end

      assign thread_state_out[t] = state_reg;
      assign pc_out[t]           = pc_reg;
      assign npc_out[t]          = npc_reg;

      smtia_trap_check u_trap (
        .ref_clk_in      (ref_clk_in),
        .reset_n_in      (reset_n_in),
        .decode_in       (decode_in[t]),
        .debug_enable_in (debug_enable_in),
        .debug_match_in  (debug_match_reg),
        .trap_out        (trap_out[t])
      );
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < CORES; c++) begin : g_core
      logic act0;
      logic act1;
      logic susp0;
      logic susp1;
      logic single;
      logic pick1;
      logic turn_reg;
      logic [1:0] err_reg;

      assign act0   = thread_state_out[2*c]   == SMTIA_ACTIVE;
      assign act1   = thread_state_out[2*c+1] == SMTIA_ACTIVE;
      assign susp0  = thread_state_out[2*c]   == SMTIA_SUSPEND;
      assign susp1  = thread_state_out[2*c+1] == SMTIA_SUSPEND;
      assign single = susp0 || susp1;

      // Alternate only when both run; otherwise the lone thread owns every cycle
      always_comb begin
        if (act0 && act1 && !single) begin
          pick1 = turn_reg;
        end else begin
          pick1 = act1 && !act0;
        end
      end

      always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          turn_reg <= 1'b0;
        end else if (act0 && act1 && !single) begin
          turn_reg <= ~turn_reg;
        end else begin
          turn_reg <= 1'b0;
        end
      end

      // At most one issue grant and one commit grant per core per cycle
      assign issue_grant_out[2*c]    = act0 && !pick1 && issue_req_in[2*c];
      assign issue_grant_out[2*c+1]  = act1 && pick1 && issue_req_in[2*c+1];
      assign commit_grant_out[2*c]   = act0 && !pick1 && commit_req_in[2*c];
      assign commit_grant_out[2*c+1] = act1 && pick1 && commit_req_in[2*c+1];

      assign single_thread_out[c]       = single;
      assign resource_pool_out[2*c]     = single && !susp0;
      assign resource_pool_out[2*c+1]   = single && !susp1;
      assign tlb_owner_out[c]           = pick1;

      // Core error goes to both threads of that core
      always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          err_reg <= 2'h0;
        end else begin
          err_reg[0] <= async_err_in[c] || sync_err_in[2*c];
          err_reg[1] <= async_err_in[c] || sync_err_in[2*c+1];
        end
      end

      assign async_err_out[2*c+1:2*c] = err_reg;
    end
  endgenerate
endmodule : smtia_arbiter

/* File: smtia_pkg.sv */
// Shared types and constants of the thread issue and commit arbiter
package smtia_pkg;
  localparam int CORE_COUNT       = 4;
  localparam int THREADS_PER_CORE = 2;
  localparam int ISSUE_WIDTH      = 4;
  localparam int ERR_WIDTH        = 8;
  localparam int INST_WIDTH       = 32;
  localparam int ADDR_WIDTH       = 64;
  localparam int ASI_WIDTH        = 8;
  localparam int TT_WIDTH         = 9;
  localparam int FTT_WIDTH        = 3;
  // Debug instruction-match register location
  localparam logic [ASI_WIDTH-1:0]  DEBUG_MATCH_ASI = 8'h60;
  localparam logic [ADDR_WIDTH-1:0] DEBUG_MATCH_VA  = 64'h0;
  // Trap type encodings
  localparam logic [TT_WIDTH-1:0]  TT_NONE          = 9'h000;
  localparam logic [TT_WIDTH-1:0]  TT_ILLEGAL_INST  = 9'h010;
  localparam logic [TT_WIDTH-1:0]  TT_FP_OTHER      = 9'h022;
  localparam logic [TT_WIDTH-1:0]  TT_ASYNC_DATA    = 9'h040;
  localparam logic [FTT_WIDTH-1:0] FTT_NONE         = 3'h0;
  localparam logic [FTT_WIDTH-1:0] FTT_UNIMPL_FPOP  = 3'h3;
  // Reset values
  localparam logic [INST_WIDTH-1:0] DEBUG_MATCH_RESET = 32'h0;
  localparam logic [ADDR_WIDTH-1:0] WATCH_RESET       = 64'h0;
  // Arbitrary serial number, not tied to any real part
  localparam logic [ADDR_WIDTH-1:0] SERIAL_DEFAULT    = 64'h0000_0000_5a5a_0001;

  typedef enum logic [2:0] {
    SMTIA_ACTIVE  = 3'b001,
    SMTIA_EMPTY   = 3'b010,
    SMTIA_SUSPEND = 3'b100
  } smtia_thread_state_t;

  typedef struct packed {
    logic                  valid;
    logic                  unimplemented;
    logic                  is_fp;
    logic [INST_WIDTH-1:0] inst;
  } smtia_decode_t;

  typedef struct packed {
    logic                  raise;
    logic [TT_WIDTH-1:0]   tt;
    logic [FTT_WIDTH-1:0]  ftt;
  } smtia_trap_t;

  typedef struct packed {
    logic                  write;
    logic [ASI_WIDTH-1:0]  asi;
    logic [ADDR_WIDTH-1:0] va;
    logic [ADDR_WIDTH-1:0] data;
  } smtia_asi_wr_t;
endpackage : smtia_pkg

/* File: smtia_trap_check.sv */
`timescale 1ns/10ps
// Per-thread trap decision for unimplemented and debug-matched instructions
module smtia_trap_check
  import smtia_pkg::*;
(
  input  wire logic                  ref_clk_in,
  input  wire logic                  reset_n_in,
  input  wire smtia_decode_t         decode_in,
  input  wire logic                  debug_enable_in,
  input  wire logic [INST_WIDTH-1:0] debug_match_in,
  output smtia_trap_t                trap_out
);
  smtia_trap_t trap_next;

  always_comb begin
    trap_next = '{raise: 1'b0, tt: TT_NONE, ftt: FTT_NONE};
    if (decode_in.valid) begin
      if (debug_enable_in && decode_in.inst == debug_match_in) begin
        trap_next = '{raise: 1'b1, tt: TT_ILLEGAL_INST, ftt: FTT_NONE};
      end else if (decode_in.unimplemented && decode_in.is_fp) begin
        trap_next = '{raise: 1'b1, tt: TT_FP_OTHER, ftt: FTT_UNIMPL_FPOP};
      end else if (decode_in.unimplemented) begin
        trap_next = '{raise: 1'b1, tt: TT_ILLEGAL_INST, ftt: FTT_NONE};
      end
    end
  end

  // Only three trap codes can leave here, so the excluded traps never occur
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trap_out <= '{raise: 1'b0, tt: TT_NONE, ftt: FTT_NONE};
    end else begin
      trap_out <= trap_next;
    end
  end
endmodule : smtia_trap_check

/* File: smtia_arbiter_chk.sv */
`timescale 1ns/10ps
// Port assertions on core 0 of the thread issue and commit arbiter
module smtia_arbiter_chk
  import smtia_pkg::*;
#(
  parameter int CORES   = CORE_COUNT,
  parameter int THREADS = CORES * THREADS_PER_CORE
)(
  input wire logic                             ref_clk_in,
  input wire logic                             reset_n_in,
  input wire logic [THREADS-1:0]               issue_req_in,
  input wire logic [CORES-1:0]                 async_err_in,
  input wire smtia_decode_t [THREADS-1:0]      decode_in,
  input wire logic                             debug_enable_in,
  input wire logic [THREADS-1:0]               issue_grant_out,
  input wire logic [THREADS-1:0]               commit_grant_out,
  input wire logic [CORES-1:0]                 single_thread_out,
  input wire logic [THREADS-1:0]               async_err_out,
  input wire smtia_trap_t [THREADS-1:0]        trap_out,
  input wire smtia_thread_state_t [THREADS-1:0] thread_state_out
);
  logic act0;
  logic act1;
  assign act0 = thread_state_out[0] == SMTIA_ACTIVE;
  assign act1 = thread_state_out[1] == SMTIA_ACTIVE;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  issue_one_a: assert property ($onehot0(issue_grant_out[1:0])) else $error("two issue grants");
  commit_one_a: assert property ($onehot0(commit_grant_out[1:0])) else $error("two commit grants");
  grant_cause_a: assert property (issue_grant_out[0] |-> issue_req_in[0] && act0) else $error("stray grant");
  alt_turn_a: assert property (act0 && act1 && &issue_req_in[1:0] ##1 act0 && act1 && &issue_req_in[1:0]
    |-> issue_grant_out[1:0] != $past(issue_grant_out[1:0])) else $error("no alternation");
  single_mode_a: assert property (single_thread_out[0] == (thread_state_out[0] == SMTIA_SUSPEND
    || thread_state_out[1] == SMTIA_SUSPEND)) else $error("wrong thread mode");
  lone_grant_a: assert property (act0 && thread_state_out[1] == SMTIA_SUSPEND && issue_req_in[0]
    |-> issue_grant_out[0]) else $error("survivor not granted");
  async_fan_a: assert property (async_err_in[0] |=> &async_err_out[1:0]) else $error("error not broadcast");
  trap_ill_a: assert property (decode_in[0].valid && decode_in[0].unimplemented && !decode_in[0].is_fp
    && !debug_enable_in |=> trap_out[0].raise && trap_out[0].tt == TT_ILLEGAL_INST) else $error("no trap");
endmodule : smtia_arbiter_chk

bind smtia_arbiter smtia_arbiter_chk #(.CORES(CORES), .THREADS(THREADS)) u_chk (.ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in), .issue_req_in(issue_req_in), .async_err_in(async_err_in), .decode_in(decode_in),
  .debug_enable_in(debug_enable_in), .issue_grant_out(issue_grant_out), .commit_grant_out(commit_grant_out),
  .single_thread_out(single_thread_out), .async_err_out(async_err_out), .trap_out(trap_out),
  .thread_state_out(thread_state_out));

/* File: smtia_pipe_model.sv */
`timescale 1ns/10ps
// Issue and commit pipelines of all threads, prompt or slow
module smtia_pipe_model
  import smtia_pkg::*;
#(
  parameter int THREADS = 8
)(
  input  wire logic                   ref_clk_in,
  input  wire logic                   slow_in,
  input  wire logic [INST_WIDTH-1:0]  match_in,
  output logic [THREADS-1:0]          issue_req_out,
  output logic [THREADS-1:0]          commit_req_out,
  output smtia_decode_t [THREADS-1:0] decode_out
);
  initial begin
    {issue_req_out, commit_req_out, decode_out} = '0;
    forever begin
      @(posedge ref_clk_in);
      #1;
      for (int t = 0; t < THREADS; t++) begin
        issue_req_out[t] = slow_in ? $urandom % 4 == 0 : 1'($urandom);
        commit_req_out[t] = slow_in ? $urandom % 4 == 0 : 1'($urandom);
        decode_out[t] = {1'($urandom), $urandom % 4 == 0, 1'($urandom), ($urandom % 2) ? match_in : $urandom};
      end
    end
  end
endmodule : smtia_pipe_model

/* File: smtia_arbiter_tb.sv */
`timescale 1ns/10ps
// Random self-checking bench of the thread issue and commit arbiter
module smtia_arbiter_tb;
  import smtia_pkg::*;
  localparam int T = CORE_COUNT * THREADS_PER_CORE;
  logic ref_clk_in = 1'b0, reset_n_in = 1'b0, slow = 1'b0, dbg_en = 1'b0, dbg_q;
  logic [T-1:0] run = '0, susp = '0, resume = '0, pcl = '0, pcl_q, iq, cq, ig, cg, aeo;
  logic [CORE_COUNT-1:0] aerr = '0, aerr_q, single, tlb;
  logic [T-1:0] pool;
  logic [ADDR_WIDTH-1:0] pa_w, va_w;
  logic [2:0] slots;
  logic [INST_WIDTH-1:0] dm = 32'hc0de_0042, dm_o;
  logic [ADDR_WIDTH-1:0] pcv = '0, pcv_q, ser, pc [T], npc [T];
  smtia_decode_t [T-1:0] dec, dec_q;
  smtia_trap_t [T-1:0] trap;
  smtia_thread_state_t [T-1:0] st, em;
  smtia_asi_wr_t asi = '0;
  int n_errors = 0;
  int checks = 0;
  bit turn [CORE_COUNT];
  always #12.5 ref_clk_in = ~ref_clk_in;
  smtia_pipe_model #(.THREADS(T)) u_pipe (.ref_clk_in(ref_clk_in), .slow_in(slow), .match_in(dm),
    .issue_req_out(iq), .commit_req_out(cq), .decode_out(dec));
  smtia_arbiter u_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .thread_run_in(run),
    .thread_suspend_in(susp), .thread_resume_in(resume), .issue_req_in(iq), .commit_req_in(cq),
    .async_err_in(aerr), .sync_err_in('0), .decode_in(dec), .debug_enable_in(dbg_en), .asi_wr_in(asi),
    .pc_load_in(pcl), .pc_value_in(pcv), .issue_grant_out(ig), .commit_grant_out(cg), .issue_slots_out(slots),
    .single_thread_out(single), .resource_pool_out(pool), .async_err_out(aeo), .trap_out(trap),
    .thread_state_out(st), .pc_out(pc), .npc_out(npc), .debug_match_out(dm_o), .pa_watch_out(pa_w),
    .va_watch_out(va_w), .serial_out(ser), .tlb_owner_out(tlb));
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask : cmp
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  function automatic logic [1:0] grant(input int c, input logic [T-1:0] rq);
    logic a0, a1;
    a0 = em[2*c] == SMTIA_ACTIVE;
    a1 = em[2*c+1] == SMTIA_ACTIVE;
    if (a0 && a1) return turn[c] ? {rq[2*c+1], 1'b0} : {1'b0, rq[2*c]};
    return {a1 & rq[2*c+1], a0 & rq[2*c]};
  endfunction : grant
  // One cycle: advance the reference model, drive new inputs, compare
  task automatic step(input bit hold1);
    smtia_decode_t d;
    logic m, r;
    @(posedge ref_clk_in);
    for (int c = 0; c < CORE_COUNT; c++) turn[c] = em[2*c] == SMTIA_ACTIVE && em[2*c+1] == SMTIA_ACTIVE && !turn[c];
    for (int t = 0; t < T; t++) begin
      if (susp[t]) em[t] = SMTIA_SUSPEND;
      else if (em[t] != SMTIA_SUSPEND) em[t] = run[t] ? SMTIA_ACTIVE : SMTIA_EMPTY;
      else if (resume[t]) em[t] = SMTIA_EMPTY;
    end
    {dec_q, aerr_q, pcl_q, pcv_q, dbg_q} = {dec, aerr, pcl, pcv, dbg_en};
    #1;
    for (int t = 0; t < T; t++) begin
      run[t] = $urandom % 10 != 0;
      susp[t] = (hold1 && t == 1) || $urandom % 40 == 0;
      resume[t] = $urandom % 8 == 0;
      pcl[t] = $urandom % 16 == 0;
    end
    aerr = 4'($urandom);
    pcv = {$urandom, $urandom};
    dbg_en = 1'($urandom);
    #1;
    for (int t = 0; t < T; t++) begin
      d = dec_q[t];
      m = dbg_q && d.inst == dm;
      r = d.valid && (m || d.unimplemented);
      cmp("state", em[t], st[t]);
      cmp("async_err", aerr_q[t/2], aeo[t]);
      cmp("trap_raise", r, trap[t].raise);
      if (r && (m || !d.is_fp)) cmp("trap_ill", {TT_ILLEGAL_INST, FTT_NONE}, {trap[t].tt, trap[t].ftt});
      if (r && !m && d.is_fp) cmp("trap_fp", {TT_FP_OTHER, FTT_UNIMPL_FPOP}, {trap[t].tt, trap[t].ftt});
      if (pcl_q[t]) cmp("pc", pcv_q, pc[t]);
      if (pcl_q[t]) cmp("npc", pcv_q + 64'h4, npc[t]);
      cmp("pool", em[t^1] == SMTIA_SUSPEND && em[t] != SMTIA_SUSPEND, pool[t]);
    end
    for (int c = 0; c < CORE_COUNT; c++) begin
      cmp("issue_grant", grant(c, iq), ig[2*c+:2]);
      cmp("commit_grant", grant(c, cq), cg[2*c+:2]);
      cmp("single", em[2*c] == SMTIA_SUSPEND || em[2*c+1] == SMTIA_SUSPEND, single[c]);
      cmp("tlb_owner", (em[2*c] == SMTIA_ACTIVE && em[2*c+1] == SMTIA_ACTIVE) ? turn[c]
        : (em[2*c+1] == SMTIA_ACTIVE && em[2*c] != SMTIA_ACTIVE), tlb[c]);
    end
    cmp("slots", ISSUE_WIDTH, slots);
  endtask : step
  initial begin
    void'($urandom(32'hf0b2bfaf));
    foreach (em[t]) em[t] = SMTIA_EMPTY;
    repeat (10) @(posedge ref_clk_in);
    #1 reset_n_in = 1'b1;
    for (int t = 0; t < T; t++) cmp("reset_state", SMTIA_EMPTY, st[t]);
    cmp("serial", SERIAL_DEFAULT, ser);
    asi = '{1'b1, DEBUG_MATCH_ASI, DEBUG_MATCH_VA, {32'h0, dm}};
    @(posedge ref_clk_in);
    #1 asi = '{1'b1, 8'h58, 64'h40, 64'h0123_4567_89ab_cdef};
    cmp("debug_match", dm, dm_o);
    @(posedge ref_clk_in);
    #1 asi = '{1'b1, 8'h58, 64'h38, 64'hfedc_ba98_7654_3210};
    cmp("pa_watch", 64'h0123_4567_89ab_cdef, pa_w);
    @(posedge ref_clk_in);
    #1 asi = '0;
    cmp("va_watch", 64'hfedc_ba98_7654_3210, va_w);
    repeat (500) step(1'b0);
    slow = 1'b1;
    repeat (500) step(1'b1);
    conclude();
  end
  initial begin
    #(25 * 2000);
    n_errors++;
    conclude();
  end
endmodule : smtia_arbiter_tb
